// ---- sdirx_pkg.sv ----
// Package for the receiver pin mode control block: mode encodings and field constants.
// Assumes a single 20 MHz clock and classic Wishbone register access.
package sdirx_pkg;
    localparam logic [3:0] SDIRX_ADDR_CTRL    = 4'h0;
    localparam logic [3:0] SDIRX_ADDR_STATUS  = 4'h4;
    localparam logic [3:0] SDIRX_ADDR_DATA    = 4'h8;
    localparam logic [31:0] SDIRX_CTRL_RESET  = 32'h00000000;
    // Control register fields
    localparam int SDIRX_CTRL_AUTO_BIT        = 0;
    // Status register fields
    localparam int SDIRX_ST_CEA_BIT           = 0;
    localparam int SDIRX_ST_W20_BIT           = 1;
    localparam int SDIRX_ST_PROC_BIT          = 2;
    localparam int SDIRX_ST_SDO_BIT           = 3;
    localparam int SDIRX_ST_STBY_BIT          = 4;
    localparam int SDIRX_ST_MODE_LSB          = 8;
    localparam int SDIRX_NUM_CTRL             = 7;
    localparam logic [31:0] SDIRX_UNMAPPED    = 32'h00000000;
    typedef enum logic [3:0] {
        SDIRX_MODE_SMPTE   = 4'h1,
        SDIRX_MODE_ASI     = 4'h2,
        SDIRX_MODE_THROUGH = 4'h4,
        SDIRX_MODE_STANDBY = 4'h8
    } sdirx_mode_e;
endpackage

// ---- sdirx_sync3.sv ----
// Three-flop synchroniser for a group of static control pins.
// Assumes pins are asynchronous to clk_i; output changes once stages two and three agree.
`timescale 1ns/1ps
module sdirx_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins in, clean levels out
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] reset_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                s1[g] <= async_i[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
                if (rst_i)
                    sync_o[g] <= reset_val_i[g];
                else if (s2[g] == s3[g])
                    sync_o[g] <= s3[g];
            end
        end
    endgenerate
endmodule

// ---- sdirx_pin_ctrl.sv ----
// Pin mode control of the serial video receiver: synchronises control pins and
// steers timing outputs, bus width, processing, loop-through and standby.
// Assumes a 20 MHz clock, a Wishbone classic master, and a word strobe from the datapath.
//
// Behaviour
// - CEA select high drives de instead of native f on the third timing output; h and v pass unchanged.
// - Bus width select high gives 20-bit bus, low gives 10-bit multiplexed bus.
// - Processing enable high runs all optional video processing, in SMPTE mode only.
// - Processing enable low bypasses processing, low-latency mode.
// - Serial output enable low parks both loop outputs high.
// - Serial output enable high drives loop data on true and complement outputs.
// - Standby high halts data processing and powers down digital I/O; here bus and timing hold, loop outputs park high, mode levels drop low, crystal copy runs on.
// - In standby both loop outputs are held high regardless of enable.
// - Buffered crystal reference copied to crystal buffer output.
// - Manual mode with both selects low gives plain serial-to-parallel conversion.
// - Manual mode with ASI high and SMPTE low gives ASI extraction.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sdirx_pin_ctrl
    import sdirx_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Control pins from board controller
    input  wire logic        cea_sync_select_i,
    input  wire logic        bus_width_select_i,
    input  wire logic        video_processing_enable_i,
    input  wire logic        serial_out_enable_i,
    input  wire logic        standby_i,
    input  wire logic        smpte_valid_select_i,
    input  wire logic        asi_extract_select_i,
    // Datapath side
    input  wire logic        word_boundary_i,
    input  wire logic        serial_data_i,
    input  wire logic        crystal_ref_i,
    input  wire logic [19:0] pixel_i,
    input  wire logic        h_i,
    input  wire logic        v_i,
    input  wire logic        f_i,
    input  wire logic        de_i,
    // Outputs
    output logic             serial_loop_out_o,
    output logic             serial_loop_out_n_o,
    output logic             crystal_buffer_out_o,
    output logic [19:0]      pout_o,
    output logic             timing_a_o,
    output logic             timing_b_o,
    output logic             timing_c_o,
    output logic             processing_on_o,
    output logic             low_latency_o,
    output logic             asi_mode_o,
    output logic             decode_on_o
);
    logic [SDIRX_NUM_CTRL-1:0] pins_s;
    logic [SDIRX_NUM_CTRL-1:0] act;
    logic        auto_mode;
    sdirx_mode_e mode;
    sdirx_mode_e next_mode;
    logic        mux_phase;

    // synchroniser; all seven pins read low out of reset until their stages agree
    sdirx_sync3 #(.W(SDIRX_NUM_CTRL)) u_sync (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .async_i     ({asi_extract_select_i, smpte_valid_select_i, standby_i, serial_out_enable_i,
                       video_processing_enable_i, bus_width_select_i, cea_sync_select_i}),
        .reset_val_i ({SDIRX_NUM_CTRL{1'b0}}),
        .sync_o      (pins_s)
    );

    // Standby acts at once; other controls swap only between words to avoid torn words
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            act <= '0;
        else
        begin
            act[4] <= pins_s[4];
            if (word_boundary_i)
                act <= pins_s;
        end
    end

    // Operating mode from selects; outside standby, auto mode treats the stream as SMPTE
    always_comb
    begin
        if (act[4])
            next_mode = SDIRX_MODE_STANDBY;
        else if (auto_mode)
            next_mode = SDIRX_MODE_SMPTE;
        else if (act[6] && !act[5])
            next_mode = SDIRX_MODE_ASI;
        else if (!act[6] && !act[5])
            next_mode = SDIRX_MODE_THROUGH;
        else
            next_mode = SDIRX_MODE_SMPTE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode <= SDIRX_MODE_STANDBY;
        else
            mode <= next_mode;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            processing_on_o <= 1'b0;
            low_latency_o   <= 1'b0;
            asi_mode_o      <= 1'b0;
            decode_on_o     <= 1'b0;
        end
        else
        begin
            processing_on_o <= act[2] && (next_mode == SDIRX_MODE_SMPTE);
            low_latency_o   <= !act[2] && !act[4];
            asi_mode_o      <= next_mode == SDIRX_MODE_ASI;
            decode_on_o     <= next_mode == SDIRX_MODE_SMPTE || next_mode == SDIRX_MODE_ASI;
        end
    end

    // Loop-through: high on both legs when disabled or in standby
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial_loop_out_o   <= 1'b1;
            serial_loop_out_n_o <= 1'b1;
        end
        else if (act[4] || !act[3])
        begin
            serial_loop_out_o   <= 1'b1;
            serial_loop_out_n_o <= 1'b1;
        end
        else
        begin
            serial_loop_out_o   <= serial_data_i;
            serial_loop_out_n_o <= !serial_data_i;
        end
    end

    // Crystal copy is a registered pass-through at this clock, not a true analogue buffer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            crystal_buffer_out_o <= 1'b0;
        else
            crystal_buffer_out_o <= crystal_ref_i;
    end

    // Parallel bus and timing; in standby outputs hold static
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pout_o     <= '0;
            mux_phase  <= 1'b0;
            timing_a_o <= 1'b0;
            timing_b_o <= 1'b0;
            timing_c_o <= 1'b0;
        end
        else if (!act[4])
        begin
            mux_phase <= act[1] ? 1'b0 : !mux_phase;
            if (act[1])
                pout_o <= pixel_i;
            else
                pout_o <= {10'h000, mux_phase ? pixel_i[9:0] : pixel_i[19:10]};
            timing_a_o <= h_i;
            timing_b_o <= v_i;
            timing_c_o <= act[0] ? de_i : f_i;
        end
    end

    // Wishbone slave: one wait state, ack for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o     <= 1'b0;
            dat_o     <= '0;
            auto_mode <= SDIRX_CTRL_RESET[SDIRX_CTRL_AUTO_BIT];
        end
        else
        begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (cyc_i && stb_i && !ack_o)
            begin
                if (adr_i == SDIRX_ADDR_CTRL)
                begin
                    if (we_i && sel_i[0])
                        auto_mode <= dat_i[SDIRX_CTRL_AUTO_BIT];
                    dat_o <= {31'h00000000, auto_mode};
                end
                else if (adr_i == SDIRX_ADDR_STATUS)
                    dat_o <= {20'h00000, mode, 3'h0, act[4:0]};
                else
                    dat_o <= SDIRX_UNMAPPED;
            end
        end
    end
endmodule

// ---- sdirx_pin_ctrl_sva.sv ----
// Checker for the pin mode control block, bound to its top ports.
// Assumes pins stay put for several clocks between changes.
`timescale 1ns/1ps
module sdirx_pin_ctrl_sva
    import sdirx_pkg::*;
(
    // Clock, reset, pins
    input wire logic clk_i, rst_i, cea_sync_select_i, bus_width_select_i, video_processing_enable_i,
    input wire logic serial_out_enable_i, standby_i, smpte_valid_select_i, asi_extract_select_i,
    // Datapath
    input wire logic word_boundary_i, serial_data_i, crystal_ref_i, f_i, de_i,
    input wire logic [19:0] pixel_i, pout_o,
    // Outputs
    input wire logic serial_loop_out_o, serial_loop_out_n_o, crystal_buffer_out_o, timing_c_o,
    input wire logic low_latency_o, asi_mode_o, decode_on_o, timing_a_o, timing_b_o,
    // Bus and native timing
    input wire logic cyc_i, stb_i, we_i, ack_o, h_i, v_i,
    input wire logic [3:0] adr_i, sel_i,
    input wire logic [31:0] dat_i
);
    logic [6:0] p, p_q;
    logic [3:0] age;
    logic       ok, run, wr, man;
    // Order: cea, width, proc, sdo, standby, smpte, asi
    assign p = {cea_sync_select_i, bus_width_select_i, video_processing_enable_i, serial_out_enable_i,
                standby_i, smpte_valid_select_i, asi_extract_select_i};
    // Judged only after sync lag and a word boundary, so legal settling never fires
    assign ok  = age == 4'h9 && p == p_q;
    assign run = ok && !p[2];
    always_ff @(posedge clk_i) p_q <= p;
    // Control writes restart settling; auto mode overrides the pin selects
    assign wr = cyc_i && stb_i && !ack_o && we_i && adr_i == SDIRX_ADDR_CTRL;
    always_ff @(posedge clk_i)
        if (rst_i) man <= !SDIRX_CTRL_RESET[SDIRX_CTRL_AUTO_BIT];
        else if (wr && sel_i[0]) man <= !dat_i[SDIRX_CTRL_AUTO_BIT];
    always_ff @(posedge clk_i)
        if (rst_i || p != p_q || wr) age <= 4'h0;
        else if (age < 4'h6 || (age > 4'h6 && age < 4'h9)) age <= age + 4'h1;
        else if (age == 4'h6 && word_boundary_i) age <= 4'h7;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_timing_sel: assert property (run |-> timing_c_o == (p[6] ? $past(de_i) : $past(f_i)))
        else $error("timing output wrong");
    chk_timing_hv: assert property (run |-> timing_a_o == $past(h_i) && timing_b_o == $past(v_i))
        else $error("h v timing wrong");
    chk_bus_width: assert property (run |-> (p[5] ? pout_o == $past(pixel_i) : pout_o[19:10] == 10'h000 &&
        (pout_o[9:0] == $past(pixel_i[9:0]) || pout_o[9:0] == $past(pixel_i[19:10]))))
        else $error("bus width wrong");
    chk_standby_hold: assert property (ok && p[2] |-> $stable(pout_o) && $stable(timing_c_o))
        else $error("standby outputs moved");
    chk_low_latency: assert property (run |-> low_latency_o == !p[4])
        else $error("latency mode wrong");
    chk_loop_park: assert property (ok && (!p[3] || p[2]) |-> serial_loop_out_o && serial_loop_out_n_o)
        else $error("loop not parked");
    chk_loop_drive: assert property (run && p[3] |->
        serial_loop_out_o == $past(serial_data_i) && serial_loop_out_n_o != serial_loop_out_o)
        else $error("loop data wrong");
    chk_xtal_copy: assert property (!$past(rst_i) |-> crystal_buffer_out_o == $past(crystal_ref_i))
        else $error("crystal copy wrong");
    chk_mode_thru: assert property (run && man && !p[1] && !p[0] |-> !decode_on_o && !asi_mode_o)
        else $error("through mode decodes");
    chk_mode_asi: assert property (run && man && !p[1] && p[0] |-> asi_mode_o && decode_on_o)
        else $error("asi mode missing");
    cover property (run && p[0] && !p[1]);
    cover property (ok && p[2] && p[3]);
    cover property (run && p[6] && p[5]);
endmodule
bind sdirx_pin_ctrl sdirx_pin_ctrl_sva i_sdirx_pin_ctrl_sva (.*);

// ---- sdirx_board_model.sv ----
// Board controller model: mode pins plus a same-clock datapath pattern.
// Assumes the bench requests pin levels; outputs change just after a rising edge.
`timescale 1ns/1ps
module sdirx_board_model (
    // Clock, reset, requested levels
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [6:0]  req_i,
    // Pins and datapath
    output logic      [6:0]  pins_o = 7'h0C,
    output logic             word_boundary_o = 1'b0,
    output logic      [19:0] pixel_o = 20'h00000,
    output logic      [3:0]  tim_o = 4'h0,
    output logic             serial_data_o = 1'b0,
    output logic             crystal_ref_o = 1'b0
);
    logic [9:0] cnt = 10'h000;
    // Datapath lines other than the upper count bits in pixel_o move often so a stuck output shows
    always @(posedge clk_i)
    begin
        pins_o          <= req_i;
        cnt             <= rst_i ? 10'h000 : cnt + 10'h001;
        word_boundary_o <= cnt[1:0] == 2'h3;
        pixel_o         <= {cnt, ~cnt};
        tim_o           <= {cnt[3], cnt[4], cnt[0] ^ cnt[1], cnt[2]};
        serial_data_o   <= cnt[0] ^ cnt[2];
        crystal_ref_o   <= cnt[0];
    end
endmodule

// ---- sdirx_pin_ctrl_test.sv ----
// Bench for the pin mode control block: bus tasks and pin mode sequences.
// Assumes the board model drives the pins; the checker is bound in.
`timescale 1ns/1ps
module sdirx_pin_ctrl_test;
    import sdirx_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, md;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [6:0]  req = 7'h0C, p;
    logic [19:0] pix;
    logic [3:0]  tim;
    logic        wb, sd, xr, ack_o, lo, lon, pon, ll, am, dec, sp;
    logic        au = 1'b0;
    int          err_count = 0, compares = 0;
    always #25 clk_i = ~clk_i;
    sdirx_board_model i_sdirx_board_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .pins_o(p),
        .word_boundary_o(wb), .pixel_o(pix), .tim_o(tim), .serial_data_o(sd), .crystal_ref_o(xr));
    sdirx_pin_ctrl i_sdirx_pin_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .cea_sync_select_i(p[6]), .bus_width_select_i(p[5]), .video_processing_enable_i(p[4]),
        .serial_out_enable_i(p[3]), .standby_i(p[2]), .smpte_valid_select_i(p[1]),
        .asi_extract_select_i(p[0]), .word_boundary_i(wb), .serial_data_i(sd), .crystal_ref_i(xr),
        .pixel_i(pix), .h_i(tim[3]), .v_i(tim[2]), .f_i(tim[1]), .de_i(tim[0]), .serial_loop_out_o(lo),
        .serial_loop_out_n_o(lon), .crystal_buffer_out_o(), .pout_o(), .timing_a_o(), .timing_b_o(),
        .timing_c_o(), .processing_on_o(pon), .low_latency_o(ll), .asi_mode_o(am), .decode_on_o(dec));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Waits for ack rather than assuming the one-cycle answer
    task automatic wb_io(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            n++;
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) err_count++;
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic run_mode(input logic [6:0] m);
        req <= m;
        repeat (16) @(posedge clk_i);
        md = m[2] ? SDIRX_MODE_STANDBY : (au || m[1]) ? SDIRX_MODE_SMPTE : m[0] ? SDIRX_MODE_ASI : SDIRX_MODE_THROUGH;
        wb_io(SDIRX_ADDR_STATUS, 1'b0, 32'h0);
        chk("status", {20'h0, md, 3'h0, m[2], m[3], m[4], m[5], m[6]}, rd);
        chk("levels", {28'h0, !m[2] && (au || m[1]) && m[4], !m[2] && !m[4], !m[2] && m[0] && !(au || m[1]),
            !m[2] && (au || m[1] || m[0])}, {28'h0, pon, ll, am, dec});
        repeat (4)
        begin
            sp = sd;
            @(posedge clk_i);
            chk("loop", m[3] && !m[2] ? {30'h0, sp, !sp} : 32'h3, {30'h0, lo, lon});
        end
    endtask
    task end_of_test;
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_io(SDIRX_ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl", SDIRX_CTRL_RESET, rd);
        wb_io(SDIRX_ADDR_CTRL, 1'b1, 32'h1);
        wb_io(SDIRX_ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h1, rd);
        wb_io(SDIRX_ADDR_CTRL, 1'b1, 32'h0);
        wb_io(4'hC, 1'b1, 32'hFFFFFFFF);
        wb_io(4'hC, 1'b0, 32'h0);
        chk("unmapped", SDIRX_UNMAPPED, rd);
        run_mode(7'h7A);
        run_mode(7'h01);
        run_mode(7'h38);
        run_mode(7'h4B);
        wb_io(SDIRX_ADDR_CTRL, 1'b1, 32'h1);
        au = 1'b1;
        run_mode(7'h19);
        wb_io(SDIRX_ADDR_CTRL, 1'b1, 32'h0);
        au = 1'b0;
        run_mode(7'h0C);
        end_of_test();
    end
    initial
    begin
        repeat (2000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end
endmodule
